// >>> design/fmm_pkg.sv
// Notes on behaviour
// - each address holds one 18-bit pixel word; 240 words per line, columns 0x00-0xEF.
// - address is line times 0x100 plus column; last address 0x13FEF.
// - shift clear, normal order: column 0 on sources 1-3, moving toward 720.
// - shift set, order swapped: column 0 starts at source 720, moving toward 1.
// - gate reverse clear maps line 0 to gate 1; set maps it to gate 320.
// - host control info is captured into index and data registers first.
// - instruction is select level, read/write level and 18-bit instruction bus together.
// - host bus is 18 bits wide so a pixel word moves in one access.
// - instructions decode into seven groups.
// - select-low write loads an 8-bit index choosing registers 0x00-0xFF.
// - address counter advances automatically after each pixel data write.
`default_nettype none
package fmm_pkg;
  localparam int unsigned PIX_W      = 18;
  localparam int unsigned INSTR_W    = 16;
  localparam int unsigned ADDR_W     = 17;
  localparam logic [7:0]  COL_LAST   = 8'hEF;
  localparam logic [8:0]  LINE_LAST  = 9'h13F;
  localparam logic [9:0]  SRC_LAST   = 10'h2CF;  // source 720, zero based
  localparam logic [7:0]  IDX_ADDR_L = 8'h20;    // address set, column
  localparam logic [7:0]  IDX_ADDR_H = 8'h21;    // address set, line
  localparam logic [7:0]  IDX_GRAM   = 8'h22;    // memory data transfer
  localparam logic [7:0]  IDX_DRV    = 8'h01;
  localparam logic [7:0]  IDX_ENTRY  = 8'h03;
  localparam int unsigned SS_BIT     = 8;
  localparam int unsigned SWAP_BIT   = 12;   // color order swap
  localparam int unsigned GREV_BIT   = 15;   // gate scan reverse
  localparam logic [ADDR_W-1:0] ADDR_RST = 17'h00000;

  typedef enum logic [2:0] {
    FMM_GRP_INDEX  = 3'h0,
    FMM_GRP_DISP   = 3'h1,
    FMM_GRP_POWER  = 3'h2,
    FMM_GRP_ADDR   = 3'h3,
    FMM_GRP_DATA   = 3'h4,
    FMM_GRP_ADJ    = 3'h5,
    FMM_GRP_WINDOW = 3'h6
  } fmm_grp_e;

  // one host instruction
  typedef struct packed {
    logic              register_select_line;
    logic              rd_nwr;
    logic [PIX_W-1:0]  bus;
  } fmm_instr_s;

  // panel position of a memory address
  typedef struct packed {
    logic              mapped;
    logic [9:0]        src_first;   // zero-based first of three source pins
    logic [8:0]        gate;        // zero-based gate line
  } fmm_pos_s;
endpackage : fmm_pkg
`default_nettype wire

// >>> design/fmm_mapper.sv
`timescale 1ns/1ps
`default_nettype none
module fmm_mapper
  import fmm_pkg::*;
(
  input  wire logic               i_clk,
  input  wire logic               i_rstn,
  input  wire logic               i_strobe,     // one-cycle instruction strobe
  input  wire fmm_instr_s         i_instr,
  input  wire logic [ADDR_W-1:0]  i_look_addr,  // address to place on panel
  output var  logic [7:0]         o_index_reg,
  output var  logic [INSTR_W-1:0] o_data_reg,
  output var  logic [ADDR_W-1:0]  o_addr,
  output var  logic [PIX_W-1:0]   o_rd_word,
  output var  fmm_grp_e           o_group,
  output var  logic               o_gate_scan_reverse,
  output var  logic               o_color_order_swap,
  output var  logic               o_source_shift,
  output var  fmm_pos_s           o_pos,
  output var  logic [PIX_W-1:0]   o_pix_word
);
  logic [PIX_W-1:0]  mem [0:(1<<ADDR_W)-1];
  logic [7:0]        index_reg_ff;
  logic [INSTR_W-1:0] data_reg_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic [ADDR_W-1:0] nxt_addr;
  logic [PIX_W-1:0]  rd_word_ff;
  logic [PIX_W-1:0]  pix_ff;
  logic              gate_rev_ff;
  logic              swap_ff;
  logic              ss_ff;
  logic              wr_idx;
  logic              wr_dat;
  logic              wr_pix;
  logic              rd_pix;
  fmm_grp_e          grp;
  fmm_pos_s          pos_ff;
  logic [PIX_W-1:0]  wr_word;
  logic [9:0]        col_x3;

  assign wr_idx = i_strobe && !i_instr.rd_nwr && !i_instr.register_select_line;
  assign wr_dat = i_strobe && !i_instr.rd_nwr && i_instr.register_select_line;
  // pixel access only through selected index
  assign wr_pix = wr_dat && (index_reg_ff == IDX_GRAM);
  assign rd_pix = i_strobe && i_instr.rd_nwr && i_instr.register_select_line
                  && (index_reg_ff == IDX_GRAM);

  always_comb
  begin
    if (!i_instr.register_select_line)
      grp = FMM_GRP_INDEX;
    else if (index_reg_ff == IDX_GRAM)
      grp = FMM_GRP_DATA;
    else if (index_reg_ff == IDX_ADDR_L || index_reg_ff == IDX_ADDR_H)
      grp = FMM_GRP_ADDR;
    else if (index_reg_ff[7:4] == 4'h1)
      grp = FMM_GRP_POWER;
    else if (index_reg_ff[7:4] == 4'h3)
      grp = FMM_GRP_ADJ;
    else if (index_reg_ff[7:4] == 4'h5)
      grp = FMM_GRP_WINDOW;
    else
      grp = FMM_GRP_DISP;
  end
  assign o_group = grp;

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      index_reg_ff <= 8'h00;
    else if (wr_idx)
      index_reg_ff <= i_instr.bus[7:0];
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      data_reg_ff <= 16'h0000;
    else if (wr_dat)
      data_reg_ff <= i_instr.bus[INSTR_W-1:0];
  end

  // scan and order bits; scan bits apply at display, memory must be rewritten after changing the order bit
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      ss_ff       <= 1'h0;
      gate_rev_ff <= 1'h0;
      swap_ff     <= 1'h0;
    end
    else if (wr_dat && index_reg_ff == IDX_DRV)
    begin
      ss_ff       <= i_instr.bus[SS_BIT];
      gate_rev_ff <= i_instr.bus[GREV_BIT];
    end
    else if (wr_dat && index_reg_ff == IDX_ENTRY)
      swap_ff <= i_instr.bus[SWAP_BIT];
  end

  // auto advance; wraps column to next line at the line end
  always_comb
  begin
    nxt_addr = addr_ff;
    if (wr_dat && index_reg_ff == IDX_ADDR_L)
      nxt_addr = {addr_ff[16:8], i_instr.bus[7:0]};
    else if (wr_dat && index_reg_ff == IDX_ADDR_H)
      nxt_addr = {i_instr.bus[8:0], addr_ff[7:0]};
    else if (wr_pix)
    begin
      if (addr_ff[7:0] >= COL_LAST)
        nxt_addr = (addr_ff[16:8] >= LINE_LAST) ? ADDR_RST
                   : {addr_ff[16:8] + 9'h001, 8'h00};
      else
        nxt_addr = addr_ff + 17'h00001;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      addr_ff <= ADDR_RST;
    else
      addr_ff <= nxt_addr;
  end

  // full 18-bit word per access; color swap reorders on write
  assign wr_word = swap_ff ? {i_instr.bus[5:0], i_instr.bus[11:6], i_instr.bus[17:12]}
                           : i_instr.bus;

  always_ff @(posedge i_clk)
  begin
    if (wr_pix && addr_ff[7:0] <= COL_LAST && addr_ff[16:8] <= LINE_LAST)
      mem[addr_ff] <= wr_word;
  end

  // read and display words registered
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      rd_word_ff <= 18'h00000;
      pix_ff     <= 18'h00000;
    end
    else
    begin
      if (rd_pix)
        rd_word_ff <= mem[addr_ff];
      pix_ff <= mem[i_look_addr];
    end
  end

  // three source pins per column; shifted order counts back from the last pin
  assign col_x3 = {1'h0, i_look_addr[7:0], 1'h0} + {2'h0, i_look_addr[7:0]};

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      pos_ff <= '0;
    else
    begin
      pos_ff.mapped    <= (i_look_addr[7:0] <= COL_LAST) && (i_look_addr[16:8] <= LINE_LAST);
      pos_ff.src_first <= ss_ff ? (SRC_LAST - 10'h002 - col_x3) : col_x3;
      pos_ff.gate      <= gate_rev_ff ? (LINE_LAST - i_look_addr[16:8]) : i_look_addr[16:8];
    end
  end

  assign o_index_reg         = index_reg_ff;
  assign o_data_reg          = data_reg_ff;
  assign o_addr              = addr_ff;
  assign o_rd_word           = rd_word_ff;
  assign o_gate_scan_reverse = gate_rev_ff;
  assign o_color_order_swap  = swap_ff;
  assign o_source_shift      = ss_ff;
  assign o_pos               = pos_ff;
  assign o_pix_word          = pix_ff;

  // checked: pixel write moves the address on
  a_addr_advance: assert property (@(posedge i_clk) disable iff (!i_rstn)
    wr_pix && addr_ff[7:0] < COL_LAST |=> addr_ff == $past(addr_ff) + 17'h00001)
    else $error("address did not advance");
  a_index_load: assert property (@(posedge i_clk) disable iff (!i_rstn)
    wr_idx |=> index_reg_ff == $past(i_instr.bus[7:0]))
    else $error("index not loaded");
  a_unmapped_col: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_look_addr[7:0] > COL_LAST |=> !pos_ff.mapped)
    else $error("unmapped column shown");
  a_gate_rev: assert property (@(posedge i_clk) disable iff (!i_rstn)
    gate_rev_ff && $stable(gate_rev_ff) && i_look_addr[16:8] == 9'h000
    |=> pos_ff.gate == LINE_LAST)
    else $error("gate reverse wrong");
  a_src_norm: assert property (@(posedge i_clk) disable iff (!i_rstn)
    !ss_ff && i_look_addr[7:0] == COL_LAST |=> $past(ss_ff) || pos_ff.src_first == 10'h2CD)
    else $error("normal source order wrong");
  a_src_shift: assert property (@(posedge i_clk) disable iff (!i_rstn)
    ss_ff && i_look_addr[7:0] == 8'h00 |=> !$past(ss_ff) || pos_ff.src_first == 10'h2CD)
    else $error("shifted source order wrong");
  a_data_cap: assert property (@(posedge i_clk) disable iff (!i_rstn)
    wr_dat |=> data_reg_ff == $past(i_instr.bus[15:0]))
    else $error("data register not captured");
  a_line_wrap: assert property (@(posedge i_clk) disable iff (!i_rstn)
    wr_pix && addr_ff[7:0] == COL_LAST && addr_ff[16:8] < LINE_LAST
    |=> addr_ff == {$past(addr_ff[16:8]) + 9'h001, 8'h00})
    else $error("line wrap wrong");
  // last mapped address, after which the counter returns to the origin
  sequence s_last_write;
    wr_pix && addr_ff[7:0] >= COL_LAST && addr_ff[16:8] >= LINE_LAST;
  endsequence
  // data write to a register that is neither address set nor memory
  sequence s_stray_data;
    wr_dat && index_reg_ff != IDX_GRAM && index_reg_ff != IDX_ADDR_L
    && index_reg_ff != IDX_ADDR_H;
  endsequence
  // checked: frame end wraps to zero
  a_frame_wrap: assert property (@(posedge i_clk) disable iff (!i_rstn)
    s_last_write |=> addr_ff == ADDR_RST)
    else $error("frame end did not wrap");
  // checked: other registers leave the counter alone
  a_addr_hold: assert property (@(posedge i_clk) disable iff (!i_rstn)
    s_stray_data |=> addr_ff == $past(addr_ff))
    else $error("address moved on a register write");
endmodule : fmm_mapper
`default_nettype wire

// >>> testbench/fmm_host.sv
`timescale 1ns/1ps
`default_nettype none
module fmm_host
  import fmm_pkg::*;
(
  input  wire logic       i_clk,
  output var  logic       o_strobe,
  output var  fmm_instr_s o_instr
);
  // idle between instructions
  initial
  begin
    o_strobe = 1'h0;
    o_instr  = '0;
  end
  task automatic send(input logic sel, input logic rnw, input logic [PIX_W-1:0] d);
    @(posedge i_clk);
    o_strobe <= 1'h1;
    o_instr  <= '{sel, rnw, d};
    @(posedge i_clk);
    o_strobe <= 1'h0;
    o_instr.bus <= ~d;  // released bus never keeps the last value
  endtask : send
  task automatic access(input logic [7:0] idx, input logic [PIX_W-1:0] d);
    send(1'h0, 1'h0, {10'h000, idx});
    send(1'h1, 1'h0, d);
  endtask : access
endmodule : fmm_host
`default_nettype wire

// >>> testbench/test_frame_memory_address_mapper.sv
`timescale 1ns/1ps
`default_nettype none
module test_frame_memory_address_mapper
  import fmm_pkg::*;
;
  logic               clk = 1'h0;
  logic               rstn = 1'h0;
  logic               strobe;
  fmm_instr_s         instr;
  logic [ADDR_W-1:0]  look = '0;
  logic [7:0]         idx;
  logic [INSTR_W-1:0] dreg;
  logic [ADDR_W-1:0]  addr;
  fmm_pos_s           pos;
  logic [PIX_W-1:0]   word;
  logic [PIX_W-1:0]   rd_word;
  fmm_grp_e           group;
  logic               gate_rev;
  logic               swap;
  logic               shift;
  int                 failures = 0;
  int                 n_compared = 0;
  int                 cycles = 0;

  always #25 clk = ~clk;
  fmm_host u_host (.i_clk(clk), .o_strobe(strobe), .o_instr(instr));
  fmm_mapper dut (.i_clk(clk), .i_rstn(rstn), .i_strobe(strobe), .i_instr(instr),
    .i_look_addr(look), .o_index_reg(idx), .o_data_reg(dreg), .o_addr(addr),
    .o_rd_word(rd_word), .o_group(group), .o_gate_scan_reverse(gate_rev),
    .o_color_order_swap(swap), .o_source_shift(shift), .o_pos(pos), .o_pix_word(word));

  task automatic tally_and_finish();
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : tally_and_finish
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // place an address, let the registered answer land
  task automatic peek(input logic [ADDR_W-1:0] a);
    @(posedge clk);
    look <= a;
    @(posedge clk);
    #1;
  endtask : peek
  task automatic set_addr(input logic [8:0] line, input logic [7:0] col);
    u_host.access(IDX_ADDR_L, {10'h000, col});
    u_host.access(IDX_ADDR_H, {9'h000, line});
  endtask : set_addr
  // last address then wrap to zero
  task automatic t_write_wrap();
    set_addr(9'h13F, 8'hEE);
    u_host.access(IDX_GRAM, 18'h2A5A5);
    #1;
    check("addr", addr, 17'h13FEF);
    check("dreg", dreg, 16'hA5A5);
    u_host.send(1'h1, 1'h0, 18'h15A5A);
    #1;
    check("wrap", addr, 17'h00000);
    peek(17'h13FEE);
    check("word", word, 18'h2A5A5);
    check("pos", pos, {1'h1, 10'h2CA, 9'h13F});
    peek(17'h13FEF);
    check("word", word, 18'h15A5A);
  endtask : t_write_wrap
  // pixel write refused outside the data index
  task automatic t_refused();
    u_host.access(IDX_DRV, 18'h00000);
    #1;
    check("index", idx, 8'h01);
    check("hold", addr, 17'h00000);
    check("grp", group, FMM_GRP_DISP);
  endtask : t_refused
  task automatic t_orient();
    u_host.access(IDX_DRV, 18'h08100);
    #1;
    check("grev", gate_rev, 1'h1);
    check("shift", shift, 1'h1);
    peek(17'h00000);
    check("rev0", pos, {1'h1, 10'h2CD, 9'h13F});
    peek(17'h13FEF);
    check("rev1", pos, {1'h1, 10'h000, 9'h000});
    peek(17'h000F0);
    check("col", pos.mapped, 1'h0);
    peek(17'h14000);
    check("line", pos.mapped, 1'h0);
  endtask : t_orient
  task automatic t_swap();
    u_host.access(IDX_ENTRY, 18'h01000);
    #1;
    check("swapbit", swap, 1'h1);
    set_addr(9'h000, 8'h05);
    u_host.access(IDX_GRAM, 18'h3F001);
    peek(17'h00005);
    check("swap", word, 18'h0103F);
  endtask : t_swap
  // read back through the data index, then a line wrap inside the frame
  task automatic t_read_wrap();
    set_addr(9'h000, 8'h05);
    #1;
    check("grp", group, FMM_GRP_ADDR);
    u_host.send(1'h0, 1'h0, {10'h000, IDX_GRAM});
    u_host.send(1'h1, 1'h1, 18'h00000);
    #1;
    check("rd", rd_word, 18'h0103F);
    check("grp", group, FMM_GRP_DATA);
    set_addr(9'h004, 8'hEF);
    u_host.access(IDX_GRAM, 18'h12345);
    #1;
    check("next", addr, 17'h00500);
  endtask : t_read_wrap

  // hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      failures++;
      tally_and_finish();
    end
  end
  initial
  begin
    repeat (8) @(posedge clk);
    rstn <= 1'h1;
    #1;
    check("rst", {idx, addr}, 25'h0);
    t_write_wrap();
    t_refused();
    t_orient();
    t_swap();
    t_read_wrap();
    tally_and_finish();
  end
endmodule : test_frame_memory_address_mapper
`default_nettype wire
